// *** design/sfps_seq.sv ***
// Flash program and status-read command sequencer on the SDRAM command bus
// Overview of operation
// R1: Any bus write into the flash region starts a program sequence.
// R2: Program step one is Load Command Register with low address byte 0x40.
// R3: That load command carries target bank and remaining address bits.
// R4: Program step two is Active with target row and bank.
// R5: Program step three is Write with column, bank and data word.
// R6: No Burst Terminate ever follows the program write.
// R7: Bus read starts status read: Load Command Register with low byte 0x70.
// R8: That load command carries bank and other address bits of the location.
// R9: Status step two is Active with bank and row of the location.
// R10: Status step three is Read with bank and column of the location.
// R11: Flash returns status on low 8 data lines after CAS latency.
// R12: Bus transfer stays pending until write issued or status byte captured.
`timescale 1ns/1ps
module sfps_seq (
  input  wire logic                          mclk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          req_i,
  input  wire logic                          wr_i,
  input  wire logic [sfps_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [sfps_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic [sfps_pkg::CL_W-1:0]     cas_lat_i,
  output logic                               ack_o,
  output logic [sfps_pkg::STAT_W-1:0]        rdata_o,
  output logic                               busy_o,
  output logic                               cs_n_o,
  output logic                               ras_n_o,
  output logic                               cas_n_o,
  output logic                               we_n_o,
  output logic [sfps_pkg::BANK_W-1:0]        ba_o,
  output logic [sfps_pkg::ROW_W-1:0]         a_o,
  output logic [sfps_pkg::DATA_W-1:0]        dq_o,
  output logic                               dq_oe_o,
  input  wire logic [sfps_pkg::DATA_W-1:0]   dq_i
);
  sfps_pkg::sfps_state_e               state_q, state_d;
  logic                                wr_q;
  logic [sfps_pkg::ADDR_W-1:0]         addr_q;
  logic [sfps_pkg::DATA_W-1:0]         wdata_q;
  logic [2:0]                          cmd_q, cmd_d;
  logic [sfps_pkg::BANK_W-1:0]         ba_d;
  logic [sfps_pkg::ROW_W-1:0]          a_d;
  logic                                oe_d;
  logic                                ack_q, ack_d;
  logic [sfps_pkg::STAT_W-1:0]         rdata_q;
  logic                                cas_start;
  logic                                capture;

  // Address fields of the latched request
  wire [sfps_pkg::BANK_W-1:0] tgt_bank = addr_q[sfps_pkg::BANK_LSB +: sfps_pkg::BANK_W];
  wire [sfps_pkg::ROW_W-1:0]  tgt_row  = addr_q[sfps_pkg::ROW_LSB +: sfps_pkg::ROW_W];
  wire [sfps_pkg::COL_W-1:0]  tgt_col  = addr_q[sfps_pkg::COL_LSB +: sfps_pkg::COL_W];
  wire [7:0]                  op_code  = wr_q ? sfps_pkg::CODE_WSETUP
                                              : sfps_pkg::CODE_RDSTAT; // R2 R7
  // Load command: code on A[7:0], the rest of the row field above it
  wire [sfps_pkg::ROW_W-1:0]  lcr_addr = {tgt_row[sfps_pkg::ROW_W-1:8], op_code}; // R3 R8

  always_comb begin
    state_d = state_q;
    cmd_d   = sfps_pkg::CMD_NOP;
    ba_d    = tgt_bank;
    a_d     = '0;
    oe_d    = 1'b0;
    ack_d   = 1'b0;
    case (state_q)
      sfps_pkg::SFPS_IDLE: begin
        if (req_i) begin
          state_d = sfps_pkg::SFPS_LCR; // R1 R7
        end
      end
      sfps_pkg::SFPS_LCR: begin
        cmd_d   = sfps_pkg::CMD_LCR; // R2 R7
        a_d     = lcr_addr; // R3 R8
        state_d = sfps_pkg::SFPS_ACT;
      end
      sfps_pkg::SFPS_ACT: begin
        cmd_d   = sfps_pkg::CMD_ACT; // R4 R9
        a_d     = tgt_row; // R4 R9
        state_d = sfps_pkg::SFPS_RW;
      end
      sfps_pkg::SFPS_RW: begin
        a_d = {{(sfps_pkg::ROW_W - sfps_pkg::COL_W){1'b0}}, tgt_col}; // R5 R10
        if (wr_q) begin
          cmd_d   = sfps_pkg::CMD_WRITE; // R5
          oe_d    = 1'b1; // R5
          ack_d   = 1'b1; // R12
          state_d = sfps_pkg::SFPS_DONE; // R6
        end else begin
          cmd_d   = sfps_pkg::CMD_READ; // R10
          state_d = sfps_pkg::SFPS_WAIT;
        end
      end
      sfps_pkg::SFPS_WAIT: begin
        if (capture) begin
          ack_d   = 1'b1; // R12
          state_d = sfps_pkg::SFPS_DONE;
        end
      end
      sfps_pkg::SFPS_DONE: begin
        // Only NOP here; single writes need no Burst Terminate
        state_d = sfps_pkg::SFPS_IDLE; // R6
      end
      default: begin
        state_d = sfps_pkg::SFPS_IDLE;
      end
    endcase
  end

  // Read command reaches the outputs at the end of SFPS_RW
  assign cas_start = (state_q == sfps_pkg::SFPS_RW) && !wr_q;

  sfps_cas_delay u_cas (
    .mclk_i    (mclk_i),
    .rstn_i    (rstn_i),
    .start_i   (cas_start),
    .cas_lat_i (cas_lat_i),
    .capture_o (capture)
  );

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      state_q <= sfps_pkg::SFPS_IDLE;
      wr_q    <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == sfps_pkg::SFPS_IDLE && req_i) begin
        wr_q    <= wr_i;
        addr_q  <= addr_i;
        wdata_q <= wdata_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cmd_q   <= sfps_pkg::CMD_NOP;
      ba_o    <= '0;
      a_o     <= '0;
      dq_o    <= '0;
      dq_oe_o <= 1'b0;
      ack_q   <= 1'b0;
    end else begin
      cmd_q   <= cmd_d;
      ba_o    <= ba_d;
      a_o     <= a_d;
      dq_o    <= wdata_q; // R5
      dq_oe_o <= oe_d;
      ack_q   <= ack_d;
    end
  end

  // Flash data is synchronous to mclk; extra stages would skew the CAS count
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rdata_q <= '0;
    end else begin
      if (ack_d && !wr_q) begin
        rdata_q <= dq_i[sfps_pkg::STAT_W-1:0]; // R11
      end
    end
  end

  assign cs_n_o  = (cmd_q == sfps_pkg::CMD_NOP);
  assign ras_n_o = cmd_q[2];
  assign cas_n_o = cmd_q[1];
  assign we_n_o  = cmd_q[0];
  assign ack_o   = ack_q;
  assign rdata_o = rdata_q;
  assign busy_o  = (state_q != sfps_pkg::SFPS_IDLE);
endmodule // sfps_seq

// *** design/sfps_pkg.sv ***
// Package with command encodings, codes and sequencer states for the flash sequencer
package sfps_pkg;
  localparam int unsigned ADDR_W     = 24;
  localparam int unsigned BANK_W     = 2;
  localparam int unsigned ROW_W      = 12;
  localparam int unsigned COL_W      = 10;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned STAT_W     = 8;
  localparam int unsigned CL_W       = 2;
  // Command encodings {ras_n, cas_n, we_n}
  localparam logic [2:0]  CMD_NOP    = 3'h7;
  localparam logic [2:0]  CMD_ACT    = 3'h3;
  localparam logic [2:0]  CMD_READ   = 3'h5;
  localparam logic [2:0]  CMD_WRITE  = 3'h4;
  localparam logic [2:0]  CMD_LCR    = 3'h0;
  // Operation codes placed on the low address byte
  localparam logic [7:0]  CODE_WSETUP = 8'h40;
  localparam logic [7:0]  CODE_RDSTAT = 8'h70;
  // Field positions inside the flat bus address
  localparam int unsigned COL_LSB    = 0;
  localparam int unsigned ROW_LSB    = 10;
  localparam int unsigned BANK_LSB   = 22;
  localparam logic [CL_W-1:0] CL_RST = 2'h2;
  typedef enum logic [2:0] {
    SFPS_IDLE, SFPS_LCR, SFPS_ACT, SFPS_RW, SFPS_WAIT, SFPS_DONE
  } sfps_state_e;
endpackage

// *** design/sfps_cas_delay.sv ***
// CAS latency counter that flags the cycle to capture read data
`timescale 1ns/1ps
module sfps_cas_delay (
  input  wire logic                       mclk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       start_i,
  input  wire logic [sfps_pkg::CL_W-1:0]  cas_lat_i,
  output logic                            capture_o
);
  logic [sfps_pkg::CL_W-1:0] cnt_q;
  logic                      run_q;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      cnt_q <= 2'h0;
      run_q <= 1'b0;
    end else if (start_i) begin
      cnt_q <= (cas_lat_i == 2'h0) ? 2'h1 : cas_lat_i;
      run_q <= 1'b1;
    end else if (run_q) begin
      if (cnt_q == 2'h0) begin
        run_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end

  // Latency of 0 is treated as 1; the flash needs at least one cycle.
  // Capture edge lands CL edges after the flash has taken the read.
  assign capture_o = run_q && (cnt_q == 2'h0);
endmodule // sfps_cas_delay

// *** sim/sfps_seq_asserts.sv ***
// Pin-level assertions for the flash program and status-read sequencer
`timescale 1ns/1ps
module sfps_seq_asserts (
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic        req_i,
  input wire logic        wr_i,
  input wire logic [23:0] addr_i,
  input wire logic [1:0]  cas_lat_i,
  input wire logic        ack_o,
  input wire logic        busy_o,
  input wire logic        cs_n_o,
  input wire logic        ras_n_o,
  input wire logic        cas_n_o,
  input wire logic        we_n_o,
  input wire logic [1:0]  ba_o,
  input wire logic [11:0] a_o,
  input wire logic        dq_oe_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wire logic [3:0] cmd  = {cs_n_o, ras_n_o, cas_n_o, we_n_o};
  wire logic [1:0] bank = addr_i[23:22];
  wire logic       take = req_i && !busy_o;
  wire logic       lcr  = cmd == {1'b0, sfps_pkg::CMD_LCR};
  wire logic       wrc  = cmd == {1'b0, sfps_pkg::CMD_WRITE};
  wire logic       rdc  = cmd == {1'b0, sfps_pkg::CMD_READ};
  AST_WR_LCR: assert property (take && wr_i |-> ##2 lcr && a_o[7:0] == sfps_pkg::CODE_WSETUP
    && ba_o == $past(bank, 2)) else $error("write setup load wrong");
  AST_RD_LCR: assert property (take && !wr_i |-> ##2 lcr && a_o[7:0] == sfps_pkg::CODE_RDSTAT
    && ba_o == $past(bank, 2)) else $error("status load wrong");
  AST_TRIPLET: assert property (lcr |=> cmd == {1'b0, sfps_pkg::CMD_ACT} && $stable(ba_o)
    ##1 (wrc || rdc) && $stable(ba_o)) else $error("command triplet broken");
  AST_WR_DATA: assert property (wrc |-> dq_oe_o && ack_o) else $error("write without data");
  AST_OE_ONLY_WR: assert property (dq_oe_o |-> wrc) else $error("data driven off write");
  AST_NO_BST: assert property (!cs_n_o |-> cmd[2:0] != 3'h6) else $error("burst stop seen");
  AST_WR_ACK: assert property (take && wr_i |-> (!ack_o)[*4] ##1 ack_o) else $error("write ack late");
  AST_RD_ACK: assert property (rdc && cas_lat_i == 2'h2 |-> (!ack_o)[*3] ##1 ack_o)
    else $error("status ack timing wrong");
  cover property (take && wr_i);
  cover property (take && !wr_i);
  cover property (rdc && cas_lat_i == 2'h0);
endmodule // sfps_seq_asserts

// *** sim/sfps_flash_model.sv ***
// Behavioural flash returning a status byte after the CAS latency
`timescale 1ns/1ps
module sfps_flash_model (
  input  wire logic        mclk_i,
  input  wire logic        rd_i,
  input  wire logic [1:0]  cas_lat_i,
  input  wire logic [7:0]  stat_i,
  output logic      [15:0] dq_o
);
  logic [3:0] hist_q = 4'h0;
  logic       tog_q  = 1'b0;
  wire  [1:0] idx    = (cas_lat_i == 2'h0) ? 2'h0 : cas_lat_i - 2'h1;
  always @(posedge mclk_i) begin
    hist_q <= {hist_q[2:0], rd_i};
    tog_q  <= ~tog_q;
  end
  // Valid one cycle only; toggling noise elsewhere so a late capture shows
  assign dq_o = hist_q[idx] ? {8'hC3, stat_i} : {16{tog_q}};
endmodule // sfps_flash_model

// *** sim/sfps_seq_tb.sv ***
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module sfps_seq_tb;
  logic mclk_i = 0, rstn_i = 0, req_i = 0, wr_i = 0, ack_o, busy_o, dq_oe_o;
  logic cs_n_o, ras_n_o, cas_n_o, we_n_o;
  logic [23:0] addr_i = 24'h0;
  logic [15:0] wdata_i = 16'h0, dq_o, dq_i;
  logic [1:0]  cas_lat_i = 2'h0, ba_o;
  logic [11:0] a_o;
  logic [7:0]  rdata_o, stat = 8'h00, last_st = 8'h00;
  logic [50:0] rows [7] = '{{1'b1, 24'h000000, 16'h1234, 2'h0, 8'h00},
    {1'b1, 24'hFFFFFF, 16'hFFFF, 2'h0, 8'h00}, {1'b0, 24'h5A3C81, 16'h0, 2'h0, 8'h81},
    {1'b0, 24'hA5C37E, 16'h0, 2'h1, 8'h5A}, {1'b0, 24'hFFFFFF, 16'h0, 2'h2, 8'h80},
    {1'b0, 24'h000001, 16'h0, 2'h3, 8'h3C}, {1'b1, 24'h5A3C81, 16'hA55A, 2'h0, 8'h00}};
  int err_count = 0, n_checks = 0, n;
  sfps_seq uut (.mclk_i, .rstn_i, .req_i, .wr_i, .addr_i, .wdata_i, .cas_lat_i, .ack_o,
    .rdata_o, .busy_o, .cs_n_o, .ras_n_o, .cas_n_o, .we_n_o, .ba_o, .a_o, .dq_o, .dq_oe_o, .dq_i);
  sfps_flash_model flash (.mclk_i, .rd_i({cs_n_o, ras_n_o, cas_n_o, we_n_o} == 4'h5),
    .cas_lat_i, .stat_i(stat), .dq_o(dq_i));
  initial forever #50 mclk_i = ~mclk_i;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic xfer(input logic [50:0] r);
    {wr_i, addr_i, wdata_i, cas_lat_i, stat} = r;
    req_i = 1;
    n = 0;
    while ({cs_n_o, ras_n_o, cas_n_o, we_n_o} !== 4'h0 && n < 9) begin
      @(negedge mclk_i);
      n++;
    end
    chk("load", {ba_o, a_o}, {r[49:48], r[47:44], r[50] ? 8'h40 : 8'h70});
    @(negedge mclk_i);
    chk("active", {cs_n_o, ras_n_o, cas_n_o, we_n_o, ba_o, a_o}, {4'h3, r[49:36]});
    @(negedge mclk_i);
    chk("rw", {cs_n_o, ras_n_o, cas_n_o, we_n_o, ba_o, a_o[9:0]},
      {1'b0, r[50] ? sfps_pkg::CMD_WRITE : sfps_pkg::CMD_READ, r[49:48], r[35:26]});
    if (r[50]) chk("wdata", {dq_oe_o, dq_o, ack_o}, {1'b1, r[25:10], 1'b1});
    n = 0;
    while (ack_o !== 1'b1 && n < 9) begin
      @(negedge mclk_i);
      n++;
    end
    chk("status", {ack_o, rdata_o}, {1'b1, r[50] ? last_st : r[7:0]});
    if (!r[50]) last_st = r[7:0];
    req_i = 0;
    @(negedge mclk_i);
    $display("Transfer %h done", r[49:26]);
  endtask
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
  initial begin
    repeat (4) @(negedge mclk_i);
    chk("reset", {cs_n_o, busy_o, ack_o, dq_oe_o, rdata_o}, {4'h8, 8'h00});
    rstn_i = 1;
    foreach (rows[i]) xfer(rows[i]);
    // Abort a status read mid-triplet; outputs must fall back to idle
    req_i = 1;
    {wr_i, cas_lat_i} = 3'h3;
    repeat (3) @(negedge mclk_i);
    req_i = 0;
    rstn_i = 0;
    repeat (2) @(negedge mclk_i);
    chk("abort", {cs_n_o, busy_o, ack_o, dq_oe_o, rdata_o}, {4'h8, 8'h00});
    rstn_i = 1;
    last_st = 8'h00;
    xfer(rows[6]);
    $display("Reset abort test done");
    finish_test();
  end
endmodule // sfps_seq_tb
bind sfps_seq sfps_seq_asserts chk (.mclk_i, .rstn_i, .req_i, .wr_i, .addr_i, .cas_lat_i,
  .ack_o, .busy_o, .cs_n_o, .ras_n_o, .cas_n_o, .we_n_o, .ba_o, .a_o, .dq_oe_o);
